//--- core/uar_pkg.sv
`default_nettype none
package uar_pkg;

  // --------------------------------------------------------------------------
  // Bus geometry
  // --------------------------------------------------------------------------
  localparam int unsigned ADR_W = 10;
  localparam int unsigned DAT_W = 32;

  // --------------------------------------------------------------------------
  // Device register indices, byte address is four times the index
  // --------------------------------------------------------------------------
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RX_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] IDX_RX_DATA = 8'h1a;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_TX_STATUS_CONTROL = 8'h98;
  localparam logic [7:0] IDX_BAUD_DIVISOR = 8'h99;

  // Reset values
  localparam logic [7:0] RST_RX_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_TX_STATUS_CONTROL = 8'h02;
  localparam logic [7:0] RST_BAUD_DIVISOR = 8'h00;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int unsigned BIT_RECEIVE_COMPLETE = 5;  // Flags and enables
  localparam int unsigned BIT_SERIAL_PORT_EN = 7;
  localparam int unsigned BIT_NINE_BIT_RX = 6;
  localparam int unsigned BIT_SINGLE_RX_EN = 5;
  localparam int unsigned BIT_CONT_RX_EN = 4;
  localparam int unsigned BIT_ADDR_DETECT_EN = 3;
  localparam int unsigned BIT_FRAMING_ERR = 2;
  localparam int unsigned BIT_OVERRUN_ERR = 1;
  localparam int unsigned BIT_RX_NINTH = 0;
  localparam int unsigned BIT_SYNC_MODE = 4;
  localparam int unsigned BIT_HIGH_SPEED_BAUD = 2;
  localparam int unsigned BIT_SHIFTER_EMPTY = 1;
  localparam logic [7:0] RX_CTRL_WR_MASK = 8'hf8;
  localparam logic [7:0] TX_CTRL_WR_MASK = 8'hfd;

  // --------------------------------------------------------------------------
  // Frame timing
  // --------------------------------------------------------------------------
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;  // Sixteen ticks per bit
  localparam logic [3:0] OVERSAMPLE_MID = 4'h7;   // Mid-bit sample point
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  // --------------------------------------------------------------------------
  // Host transmitter registers, byte addresses
  // --------------------------------------------------------------------------
  localparam logic [ADR_W-1:0] HOST_ADR_DATA = 10'h000;
  localparam logic [ADR_W-1:0] HOST_ADR_STATUS = 10'h004;
  localparam logic [ADR_W-1:0] HOST_ADR_DIVISOR = 10'h008;
  localparam logic [ADR_W-1:0] HOST_ADR_CONTROL = 10'h00c;
  localparam logic [15:0] RST_HOST_DIVISOR = 16'h0010;
  localparam logic [3:0] FRAME_BITS_8 = 4'ha;
  localparam logic [3:0] FRAME_BITS_9 = 4'hb;

  // Receiver states, Gray along idle, start, data, stop
  typedef enum logic [1:0] {
    UAR_IDLE = 2'b00,
    UAR_START = 2'b01,
    UAR_DATA = 2'b11,
    UAR_STOP = 2'b10
  } uar_rx_state_type;

endpackage
`default_nettype wire

//--- core/uar_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// Serial line from the transmitting host to the receiving device
interface uar_link_if;
  logic line;
  modport dev (input line);
  modport host (output line);
endinterface
`default_nettype wire

//--- core/uar_tx_host.sv
`timescale 1ns/10ps
`default_nettype none
module uar_tx_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [uar_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [uar_pkg::DAT_W-1:0] wb_dat_i,
  output logic [uar_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  uar_link_if.host link
);
  import uar_pkg::*;

  logic ack_q;
  logic [DAT_W-1:0] dat_q;
  logic [15:0] div_q;
  logic nine_q;
  logic busy_q;
  logic [10:0] frame_q;
  logic [3:0] bits_q;
  logic [15:0] tmr_q;
  logic line_q;
  logic wr_en;
  logic start_tx;

  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
  assign start_tx = wr_en & (wb_adr_i == HOST_ADR_DATA) & ~busy_q;

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  // Single-cycle acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end
  end

  // Read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
      unique case (wb_adr_i)
        HOST_ADR_STATUS: dat_q <= {31'h0, busy_q};
        HOST_ADR_DIVISOR: dat_q <= {16'h0, div_q};
        HOST_ADR_CONTROL: dat_q <= {31'h0, nine_q};
        default: dat_q <= '0;
      endcase
    end
  end

  // Configuration
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= RST_HOST_DIVISOR;
      nine_q <= 1'b0;
    end else if (wr_en & ~busy_q) begin
      if (wb_adr_i == HOST_ADR_DIVISOR) begin
        div_q <= wb_dat_i[15:0];
      end
      if (wb_adr_i == HOST_ADR_CONTROL) begin
        nine_q <= wb_dat_i[0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Frame shifter: start, data LSB first, ninth bit, stop
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      frame_q <= '1;
      bits_q <= '0;
      tmr_q <= '0;
      line_q <= 1'b1;
    end else if (start_tx) begin
      busy_q <= 1'b1;
      // Ninth bit one marks an address, zero marks data
      frame_q <= {1'b1, (nine_q ? wb_dat_i[8] : 1'b1), wb_dat_i[7:0], 1'b0};
      bits_q <= nine_q ? FRAME_BITS_9 : FRAME_BITS_8;
      tmr_q <= '0;
    end else if (busy_q) begin
      if (tmr_q == 16'h0) begin
        line_q <= frame_q[0];
        frame_q <= {1'b1, frame_q[10:1]};
        tmr_q <= (div_q == 16'h0) ? 16'h0 : div_q - 16'h1;
        if (bits_q == 4'h0) begin
          busy_q <= 1'b0;
          line_q <= 1'b1;
        end else begin
          bits_q <= bits_q - 4'h1;
        end
      end else begin
        tmr_q <= tmr_q - 16'h1;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign link.line = line_q;

endmodule  // uar_tx_host
`default_nettype wire

//--- core/uar_rx_dev.sv
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module uar_rx_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [uar_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [uar_pkg::DAT_W-1:0] wb_dat_i,
  output logic [uar_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic rx_irq_o,
  uar_link_if.dev link
);
  import uar_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic ack_q;
  logic [DAT_W-1:0] dat_q;
  logic irq_q;
  logic [7:0] ctrl_q;
  logic [7:0] ien_q;
  logic [7:0] txc_q;
  logic [7:0] div_q;
  logic overrun_error_flag_q;
  logic [9:0] fifo_q [0:1];  // {framing error, ninth bit, data}
  logic [1:0] cnt_q;
  logic [9:0] tick_q;
  logic [3:0] os_q;
  logic [3:0] bit_q;
  logic [8:0] shifter_q;
  uar_rx_state_type state_q;
  logic [7:0] idx;
  logic req;
  logic wr_en;
  logic rd_pop;
  logic rx_run;
  logic tick;
  logic [9:0] tick_top;
  logic nine;
  logic addr_mode;
  logic frame_end;
  logic accept;
  logic push;
  logic [9:0] head;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & ack_q & wb_sel_i[0];
  assign rd_pop = req & ~wb_we_i & ack_q & (idx == IDX_RX_DATA) & (cnt_q != 2'h0);
  assign nine = ctrl_q[BIT_NINE_BIT_RX];
  // Address detect only counts in nine-bit mode
  assign addr_mode = ctrl_q[BIT_ADDR_DETECT_EN] & nine;
  // Serial port on, asynchronous, and a receive enable set
  assign rx_run = ctrl_q[BIT_SERIAL_PORT_EN] & ~txc_q[BIT_SYNC_MODE]
                & (ctrl_q[BIT_CONT_RX_EN] | ctrl_q[BIT_SINGLE_RX_EN]);
  assign head = fifo_q[0];

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  // Acknowledge one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data, framing error and ninth bit show the head of the FIFO
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (req & ~ack_q) begin
      unique case (idx)
        IDX_IRQ_FLAGS: dat_q <= {24'h0, 2'b00, (cnt_q != 2'h0), 5'h00};
        IDX_RX_STATUS_CONTROL: dat_q <= {24'h0, ctrl_q[7:3], head[9], overrun_error_flag_q, head[8]};
        IDX_RX_DATA: dat_q <= {24'h0, head[7:0]};
        IDX_IRQ_ENABLES: dat_q <= {24'h0, ien_q};
        IDX_TX_STATUS_CONTROL: dat_q <= {24'h0, txc_q | RST_TX_STATUS_CONTROL};
        IDX_BAUD_DIVISOR: dat_q <= {24'h0, div_q};
        default: dat_q <= '0;
      endcase
    end
  end

  // Control and configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= RST_RX_STATUS_CONTROL;
      ien_q <= RST_IRQ_ENABLES;
      txc_q <= RST_TX_STATUS_CONTROL & ~(8'h1 << BIT_SHIFTER_EMPTY);
      div_q <= RST_BAUD_DIVISOR;
    end else if (wr_en) begin
      unique case (idx)
        IDX_RX_STATUS_CONTROL: ctrl_q <= wb_dat_i[7:0] & RX_CTRL_WR_MASK;
        IDX_IRQ_ENABLES: ien_q <= wb_dat_i[7:0];
        IDX_TX_STATUS_CONTROL: txc_q <= wb_dat_i[7:0] & TX_CTRL_WR_MASK;
        IDX_BAUD_DIVISOR: div_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end else if (push & ~ctrl_q[BIT_CONT_RX_EN]) begin
      // Single receive ends after one buffered word
      ctrl_q[BIT_SINGLE_RX_EN] <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Oversampling tick, sixteen per bit
  // --------------------------------------------------------------------------
  // Low speed divides a further four times
  assign tick_top = txc_q[BIT_HIGH_SPEED_BAUD] ? {2'b00, div_q} : {div_q, 2'b11};
  assign tick = (tick_q == tick_top);

  always_ff @(posedge clk_i) begin
    if (rst_i | ~rx_run | tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 10'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Frame receiver
  // --------------------------------------------------------------------------
  assign frame_end = tick & (state_q == UAR_STOP) & (os_q == OVERSAMPLE_LAST);

  // Start, data bits LSB first, stop, each sampled mid-bit
  always_ff @(posedge clk_i) begin
    if (rst_i | ~rx_run) begin
      state_q <= UAR_IDLE;
      os_q <= '0;
      bit_q <= '0;
      shifter_q <= '0;
    end else if (tick) begin
      os_q <= os_q + 4'h1;
      unique case (state_q)
        UAR_IDLE: begin
          os_q <= '0;
          if (~link.line) begin
            state_q <= UAR_START;
          end
        end
        UAR_START: begin
          if (os_q == OVERSAMPLE_MID) begin
            os_q <= '0;
            bit_q <= '0;
            // Glitch shorter than half a bit is no start
            state_q <= link.line ? UAR_IDLE : UAR_DATA;
          end
        end
        UAR_DATA: begin
          if (os_q == OVERSAMPLE_LAST) begin
            // A new frame overwrites whatever was ignored before
            shifter_q[bit_q] <= link.line;
            bit_q <= bit_q + 4'h1;
            if (bit_q == (nine ? DATA_BITS_9 : DATA_BITS_8) - 4'h1) begin
              state_q <= UAR_STOP;
            end
          end
        end
        UAR_STOP: begin
          if (os_q == OVERSAMPLE_LAST) begin
            state_q <= UAR_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Receive FIFO, two entries
  // --------------------------------------------------------------------------
  // Data frames are dropped under address detect
  assign accept = ~addr_mode | shifter_q[8];
  // Transfers blocked while overrun stands
  assign push = frame_end & accept & ~overrun_error_flag_q & ((cnt_q != FIFO_DEPTH) | rd_pop);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
    end else begin
      if (rd_pop) begin
        fifo_q[0] <= fifo_q[1];
      end
      if (push) begin
        // Framing error and ninth bit travel with the byte
        if (cnt_q - {1'b0, rd_pop} == 2'h0) begin
          fifo_q[0] <= {~link.line, (nine & shifter_q[8]), shifter_q[7:0]};
        end else begin
          fifo_q[1] <= {~link.line, (nine & shifter_q[8]), shifter_q[7:0]};
        end
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, rd_pop};
    end
  end

  // Overrun sticks until the continuous enable is cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overrun_error_flag_q <= 1'b0;
    end else if (frame_end & accept & ~overrun_error_flag_q & (cnt_q == FIFO_DEPTH) & ~rd_pop) begin
      overrun_error_flag_q <= 1'b1;
    end else if (~ctrl_q[BIT_CONT_RX_EN]) begin
      overrun_error_flag_q <= 1'b0;
    end
  end

  // Interrupt request from complete flag and its enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (cnt_q + {1'b0, push} - {1'b0, rd_pop} != 2'h0)
             & ien_q[BIT_RECEIVE_COMPLETE];
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign rx_irq_o = irq_q;

endmodule  // uar_rx_dev
`default_nettype wire

//--- sim/uar_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module uar_link_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [uar_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [uar_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [uar_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic rx_irq_o
);
  import uar_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic ien_q;

  // Mirror of the receive interrupt enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_q <= 1'b0;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 10'h230) begin
      ien_q <= wb_dat_i[5];
    end
  end

  // ----------------------------------------
  // Bus and line properties
  // ----------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_start;
    $fell(line);
  endsequence

  a_ack_follows: assert property (s_req |=> wb_ack_o)
    else $error("ack did not follow request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_rdata_holds: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data changed while idle");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_irq_enable: assert property (rx_irq_o |-> $past(ien_q))
    else $error("irq while disabled");
  a_start_low: assert property (s_start |-> !line [*8])
    else $error("start bit too short");
  a_idle_high: assert property ($fell(rst_i) |-> line)
    else $error("line not idle high after reset");
endmodule // uar_link_asserts
`default_nettype wire

//--- sim/async_uart_receiver_addr_detect_test.sv
`timescale 1ns/10ps
`default_nettype none
module async_uart_receiver_addr_detect_test;
  import uar_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic tgt = 1'b0;
  logic [9:0] adr = 10'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] d_rdat;
  logic [31:0] h_rdat;
  logic d_ack;
  logic h_ack;
  logic rx_irq;
  int miscompares = 0;
  int cmp_count = 0;
  uar_link_if link();

  // Clock
  always #5 clk_i = ~clk_i;

  // Device and host joined by the link
  uar_rx_dev uar_rx_dev_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc & ~tgt),
    .wb_stb_i(stb & ~tgt), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(d_rdat), .wb_ack_o(d_ack), .rx_irq_o(rx_irq), .link(link.dev));
  uar_tx_host uar_tx_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc & tgt),
    .wb_stb_i(stb & tgt), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(h_rdat), .wb_ack_o(h_ack), .link(link.host));
  uar_link_asserts uar_link_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .line(link.line),
    .wb_cyc_i(cyc & ~tgt), .wb_stb_i(stb & ~tgt), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(d_rdat), .wb_ack_o(d_ack), .rx_irq_o(rx_irq));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic give_verdict();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic fail();
    miscompares++;
    give_verdict();
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h0, got}, {7'h0, exp});
  endtask

  // One classic cycle, t selects the host
  task automatic bus(input logic t, input logic w, input logic [9:0] a, input logic [8:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    tgt <= t;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {23'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while ((t ? h_ack : d_ack) !== 1'b1 && n < 20);
    q = t ? h_rdat[7:0] : d_rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) fail();
  endtask

  task automatic wr(input logic t, input logic [9:0] a, input logic [8:0] d);
    logic [7:0] q;
    bus(t, 1'b1, a, d, q);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, 1'b0, a, 9'h0, q);
    cmp8(q, e);
  endtask

  // Read back a host register
  task automatic rdh(input logic [9:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b1, 1'b0, a, 9'h0, q);
    cmp8(q, e);
  endtask

  // Host sends a frame, the wire is checked at each mid-bit
  task automatic send(input logic [8:0] d, input int nb);
    int n;
    wr(1'b1, 10'h000, d);
    n = 0;
    while (link.line !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) fail();
    repeat (16) @(posedge clk_i);
    cmp1(link.line, 1'b0);
    for (int i = 0; i < nb; i++) begin
      repeat (32) @(posedge clk_i);
      cmp1(link.line, d[i]);
    end
    repeat (32) @(posedge clk_i);
    cmp1(link.line, 1'b1);
    repeat (64) @(posedge clk_i);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(10'h030, 8'h00);
    rd(10'h060, 8'h00);
    rd(10'h068, 8'h00);
    rd(10'h230, 8'h00);
    rd(10'h260, 8'h02);
    rd(10'h264, 8'h00);
    rd(10'h3fc, 8'h00);
    wr(1'b0, 10'h260, 9'h004);
    wr(1'b0, 10'h264, 9'h001);
    wr(1'b0, 10'h230, 9'h020);
    wr(1'b0, 10'h060, 9'h0d7);
    rd(10'h060, 8'hd0);
    wr(1'b1, 10'h008, 9'h020);
    wr(1'b1, 10'h00c, 9'h001);
    rdh(10'h008, 8'h20);
    rdh(10'h00c, 8'h01);
    // Nine-bit frames without address detect
    send(9'h1a5, 9);
    send(9'h03c, 9);
    cmp1(rx_irq, 1'b1);
    rd(10'h030, 8'h20);
    rd(10'h060, 8'hd1);
    rd(10'h068, 8'ha5);
    rd(10'h060, 8'hd0);
    rd(10'h068, 8'h3c);
    rd(10'h030, 8'h00);
    cmp1(rx_irq, 1'b0);
    // Overrun and recovery
    send(9'h011, 9);
    send(9'h022, 9);
    send(9'h033, 9);
    rd(10'h060, 8'hd2);
    rd(10'h068, 8'h11);
    rd(10'h068, 8'h22);
    send(9'h044, 9);
    rd(10'h030, 8'h00);
    wr(1'b0, 10'h060, 9'h0c0);
    wr(1'b0, 10'h060, 9'h0d0);
    send(9'h055, 9);
    rd(10'h060, 8'hd0);
    rd(10'h068, 8'h55);
    // Address detect
    wr(1'b0, 10'h060, 9'h0d8);
    send(9'h044, 9);
    rd(10'h030, 8'h00);
    cmp1(rx_irq, 1'b0);
    send(9'h066, 9);
    send(9'h1c3, 9);
    rd(10'h060, 8'hd9);
    rd(10'h068, 8'hc3);
    rd(10'h030, 8'h00);
    wr(1'b0, 10'h060, 9'h0d0);
    send(9'h077, 9);
    rd(10'h068, 8'h77);
    // Address enable without nine-bit mode, irq masked
    wr(1'b0, 10'h230, 9'h000);
    wr(1'b1, 10'h00c, 9'h000);
    wr(1'b0, 10'h060, 9'h098);
    send(9'h0e1, 8);
    cmp1(rx_irq, 1'b0);
    rd(10'h030, 8'h20);
    wr(1'b0, 10'h230, 9'h020);
    repeat (2) @(posedge clk_i);
    cmp1(rx_irq, 1'b1);
    rd(10'h068, 8'he1);
    // Receive enables
    wr(1'b0, 10'h060, 9'h080);
    send(9'h0f0, 8);
    rd(10'h030, 8'h00);
    wr(1'b0, 10'h060, 9'h0a0);
    send(9'h05a, 8);
    rd(10'h060, 8'h80);
    rd(10'h068, 8'h5a);
    // Nine-bit host into eight-bit receiver, stop lands on a zero ninth bit
    wr(1'b1, 10'h00c, 9'h001);
    wr(1'b0, 10'h060, 9'h090);
    send(9'h0b4, 9);
    rd(10'h060, 8'h94);
    rd(10'h068, 8'hb4);
    give_verdict();
  end
endmodule // async_uart_receiver_addr_detect_test
`default_nettype wire
